// ==== pkg/dasc_defs.svh ====
// Purpose: Offsets, field positions, reset values and timing counts for the serial channel
// Assumes: Three-bit register address, eight-bit data bus
// Notes:   Included by the design files and the test bench
`ifndef DASC_DEFS_SVH
`define DASC_DEFS_SVH
`define DASC_ADR_DATA     3'h0
`define DASC_ADR_IEN      3'h1
`define DASC_ADR_IID      3'h2
`define DASC_ADR_LFMT     3'h3
`define DASC_ADR_MCTL     3'h4
`define DASC_ADR_LSTAT    3'h5
`define DASC_ADR_MSTAT    3'h6
`define DASC_ADR_SCR      3'h7
`define DASC_LF_DLAB      7
`define DASC_LF_BREAK     6
`define DASC_LF_STICK     5
`define DASC_LF_EVEN      4
`define DASC_LF_PAR       3
`define DASC_LF_STOP      2
`define DASC_MC_LOOP      4
`define DASC_MC_IRQEN     3
`define DASC_IID_LINE     3'h6
`define DASC_IID_RXD      3'h4
`define DASC_IID_TXE      3'h2
`define DASC_IID_MODEM    3'h0
`define DASC_IID_NONE     3'h1
`define DASC_DIV_RESET    16'h0002
`define DASC_START_MID    4'h7
`define DASC_OVS          5'h10
`endif

// ==== pkg/dasc_pkg.sv ====
// Purpose: Types shared by the serial channel design
// Assumes: Constants come from dasc_defs.svh
// Notes:   State enums carry explicit binary codes
package dasc_pkg;
	typedef enum logic [2:0] {
		DASC_TX_IDLE  = 3'b000,
		DASC_TX_START = 3'b001,
		DASC_TX_DATA  = 3'b010,
		DASC_TX_PAR   = 3'b011,
		DASC_TX_STOP  = 3'b100
	} dasc_tx_st_t;
	typedef enum logic [2:0] {
		DASC_RX_IDLE  = 3'b000,
		DASC_RX_START = 3'b001,
		DASC_RX_DATA  = 3'b010,
		DASC_RX_PAR   = 3'b011,
		DASC_RX_STOP  = 3'b100
	} dasc_rx_st_t;
	typedef struct packed {
		logic       cs_n;
		logic       rd_n;
		logic       wr_n;
		logic [2:0] adr;
		logic [7:0] wdata;
	} dasc_bus_t;
	typedef struct packed {
		logic cts_n;
		logic dsr_n;
		logic ri_n;
		logic cd_n;
	} dasc_modem_in_t;
	typedef struct packed {
		logic [15:0] cnt;
		logic        tick;
	} dasc_baud_t;
endpackage : dasc_pkg

// ==== rtl/dasc_baud.sv ====
// Purpose: Baud divider giving a one-cycle tick at sixteen times the bit rate
// Assumes: Divisor between 2 and 65535; values below 2 are treated as 2
// Notes:   Counter restarts when it passes the divisor after a reprogram
`timescale 1ns/1ns
`include "dasc_defs.svh"
module dasc_baud
	import dasc_pkg::*;
(
	input  wire logic        i_sys_clk,
	input  wire logic        i_rst,
	input  wire logic [15:0] i_divisor,
	output logic             o_tick
);
	dasc_baud_t st_q;
	dasc_baud_t st_d;
	logic [15:0] div_eff;

	// Clamp low divisors so the tick never runs at the full clock rate
	always_comb begin
		div_eff = (i_divisor < 16'h0002) ? 16'h0002 : i_divisor;
		st_d    = st_q;
		st_d.tick = 1'b0;
		if (st_q.cnt >= div_eff - 16'h0001) begin
			st_d.cnt  = 16'h0000;
			st_d.tick = 1'b1;
		end else begin
			st_d.cnt = st_q.cnt + 16'h0001;
		end
	end

	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign o_tick = st_q.tick;
endmodule : dasc_baud

// ==== rtl/dasc_channel.sv ====
// Purpose: One asynchronous serial channel with registers, modem lines and interrupt
// Assumes: Host strobes, chip select and serial/modem pins are asynchronous to i_sys_clk
// Notes:   Two instances form the dual device; bus and clock are shared outside
//
// What this block does
// - Two independent channels share bus, reset, clock
// - Own programmable baud generator per channel
// - Bit zero is first serial bit
// - Serial input high is one, low zero
// - Loopback feeds receiver from own transmitter
// - Serial output mark in reset, loopback, idle
// - Frame: start, data, optional parity, stop
// - Five to eight data bits selectable
// - Even, odd or no parity generated, checked
// - Respond only while chip select low
// - Write strobe low stores addressed register
// - Read strobe low drives data bus
// - Three address lines select eight registers
// - Divisor latch bit remaps addresses zero, one
// - Interrupt high on any enabled condition
// - Enable bits zero to three, rest zero
// - Interrupt enable output follows modem control
// - Control bit one drives request-to-send low outside loopback
// - Control bit zero drives terminal-ready low outside loopback
// - Reset clears registers, sets divisor to two, idles serial lines
// - Clear-to-send readable, no effect on transfer
// - Other modem inputs only reported as status
// - Stop bits one, one-and-half or two
// - Identity codes prioritised, bit zero pending
// - Divisor two to 65535 gives sixteen-times clock
// - Start bit checked at its centre
`timescale 1ns/1ns
`include "dasc_defs.svh"
module dasc_channel
	import dasc_pkg::*;
(
	input  wire logic           i_sys_clk,
	input  wire logic           i_rst,
	input  wire dasc_bus_t      i_bus,
	output logic [7:0]          o_rdata,
	output logic                o_rdata_oe,
	input  wire logic           i_rx,
	output logic                o_tx,
	input  wire dasc_modem_in_t i_modem,
	output logic                o_rts_n,
	output logic                o_dtr_n,
	output logic                o_irq,
	output logic                o_irq_oe,
	output logic                o_irq_enable_out_n
);
	// per-channel state; one instance per channel
	typedef struct packed {
		logic [2:0]  cs_s1, cs_s2, rd_s1, rd_s2, wr_s1, wr_s2;
		logic [11:0] bus_s1, bus_s2;
		logic        rd_prev, wr_prev;
		logic [1:0]  rx_s;
		logic [7:0]  mdm_s;
		logic [7:0]  line_format, irq_enable, modem_control, scratch;
		logic [15:0] divisor;
		logic [7:0]  tx_holding, tx_shift, rx_holding, rx_shift;
		logic        thr_empty, data_ready, overrun, par_err, frm_err, brk;
		logic [3:0]  mdm_prev, mdm_delta;
		logic        thre_irq;
		dasc_tx_st_t tx_st;
		logic [4:0]  tx_ovs;
		logic [2:0]  tx_bit;
		logic        tx_half, tx_line;
		dasc_rx_st_t rx_st;
		logic [3:0]  rx_ovs;
		logic [2:0]  rx_bit;
		logic        rx_prev, rx_par, rx_zero;
		logic [7:0]  rdata;
		logic        rd_act;
	} chan_st_t;
	chan_st_t st_q;
	chan_st_t st_d;
	logic       tick;
	logic       rx_in;
	logic [3:0] mdm_now;
	logic       rd_fall, wr_fall, sel;
	logic [2:0] adr;
	logic [7:0] wd;
	logic [2:0] nbits;
	logic       dlab, loop;
	logic [2:0] iid;

	dasc_baud u_baud (
		.i_sys_clk (i_sys_clk),
		.i_rst     (i_rst),
		.i_divisor (st_q.divisor),
		.o_tick    (tick)
	);

	// Parity over the active data bits
	function automatic logic par_of(input logic [7:0] d, input logic [1:0] wl);
		logic [7:0] m;
		m = 8'h1F << 0;
		case (wl)
			2'b00: m = 8'h1F;
			2'b01: m = 8'h3F;
			2'b10: m = 8'h7F;
			default: m = 8'hFF;
		endcase
		par_of = ^(d & m);
	endfunction : par_of

	// Expected parity bit from line format; stick parity forces a constant
	function automatic logic par_bit(input logic [7:0] d, input logic [7:0] lf);
		if (lf[`DASC_LF_STICK]) begin
			par_bit = ~lf[`DASC_LF_EVEN];
		end else begin
			par_bit = par_of(d, lf[1:0]) ^ ~lf[`DASC_LF_EVEN];
		end
	endfunction : par_bit

	// Helper views of the synchronised bus and line
	always_comb begin
		dlab    = st_q.line_format[`DASC_LF_DLAB];
		loop    = st_q.modem_control[`DASC_MC_LOOP];
		adr     = st_q.bus_s2[10:8];
		wd      = st_q.bus_s2[7:0];
		// strobes count only with chip select low
		sel     = ~st_q.cs_s2[0];
		rd_fall = sel & ~st_q.rd_s2[0] & st_q.rd_prev;
		wr_fall = sel & ~st_q.wr_s2[0] & st_q.wr_prev;
		// loopback takes the transmitter line internally
		rx_in   = loop ? st_q.tx_line : st_q.rx_s[1];
		// loopback status sources come from modem control
		// modem inputs only reported, never gate transfer
		mdm_now = loop ? {st_q.modem_control[3], st_q.modem_control[2],
			st_q.modem_control[0], st_q.modem_control[1]}
			: {~st_q.mdm_s[7], ~st_q.mdm_s[6], ~st_q.mdm_s[5], ~st_q.mdm_s[4]};
		nbits   = {1'b1, st_q.line_format[1:0]} - 3'h4 + 3'h4;
		// Kept as a signal so the pin follows register changes
		iid     = iid_code();
	end

	// Next state: synchronisers, register file, transmitter, receiver
	always_comb begin
		st_d = st_q;
		// Two flops on every pin before use
		st_d.cs_s1  = {3{i_bus.cs_n}};
		st_d.cs_s2  = st_q.cs_s1;
		st_d.rd_s1  = {3{i_bus.rd_n}};
		st_d.rd_s2  = st_q.rd_s1;
		st_d.wr_s1  = {3{i_bus.wr_n}};
		st_d.wr_s2  = st_q.wr_s1;
		st_d.bus_s1 = {1'b0, i_bus.adr, i_bus.wdata};
		st_d.bus_s2 = st_q.bus_s1;
		st_d.rd_prev = st_q.rd_s2[0] | ~sel;
		st_d.wr_prev = st_q.wr_s2[0] | ~sel;
		st_d.rx_s   = {st_q.rx_s[0], i_rx};
		st_d.mdm_s  = {st_q.mdm_s[3:0], i_modem.cd_n, i_modem.ri_n,
			i_modem.dsr_n, i_modem.cts_n};
		st_d.mdm_prev = mdm_now;
		st_d.rd_act = sel & ~st_q.rd_s2[0];

		if (wr_fall) begin
			case (adr)
				`DASC_ADR_DATA: begin
					if (dlab) begin
						st_d.divisor[7:0] = wd;
					end else begin
						st_d.tx_holding = wd;
						st_d.thr_empty  = 1'b0;
						st_d.thre_irq   = 1'b0;
					end
				end
				`DASC_ADR_IEN: begin
					if (dlab) begin
						st_d.divisor[15:8] = wd;
					end else begin
						st_d.irq_enable = {4'h0, wd[3:0]};
					end
				end
				`DASC_ADR_LFMT: st_d.line_format   = wd;
				`DASC_ADR_MCTL: st_d.modem_control = {3'h0, wd[4:0]};
				`DASC_ADR_SCR:  st_d.scratch       = wd;
				default: ;
			endcase
		end

		// read data captured on the strobe, with clear-on-read side effects
		if (rd_fall) begin
			case (adr)
				`DASC_ADR_DATA: begin
					st_d.rdata      = dlab ? st_q.divisor[7:0] : st_q.rx_holding;
					if (!dlab) st_d.data_ready = 1'b0;
				end
				`DASC_ADR_IEN:  st_d.rdata = dlab ? st_q.divisor[15:8] : st_q.irq_enable;
				`DASC_ADR_IID: begin
					st_d.rdata = {5'h00, iid};
					if (iid == `DASC_IID_TXE) st_d.thre_irq = 1'b0;
				end
				`DASC_ADR_LFMT: st_d.rdata = st_q.line_format;
				`DASC_ADR_MCTL: st_d.rdata = st_q.modem_control;
				`DASC_ADR_LSTAT: begin
					// line status layout; errors clear on read
					st_d.rdata = {1'b0, st_q.thr_empty & (st_q.tx_st == DASC_TX_IDLE),
						st_q.thr_empty, st_q.brk, st_q.frm_err, st_q.par_err,
						st_q.overrun, st_q.data_ready};
					st_d.overrun = 1'b0;
					st_d.par_err = 1'b0;
					st_d.frm_err = 1'b0;
					st_d.brk     = 1'b0;
				end
				`DASC_ADR_MSTAT: begin
					st_d.rdata     = {mdm_now, st_q.mdm_delta};
					st_d.mdm_delta = 4'h0;
				end
				default: st_d.rdata = st_q.scratch;
			endcase
		end

		// change flags; set wins over a read clear
		st_d.mdm_delta[0] = st_d.mdm_delta[0] | (mdm_now[0] ^ st_q.mdm_prev[0]);
		st_d.mdm_delta[1] = st_d.mdm_delta[1] | (mdm_now[1] ^ st_q.mdm_prev[1]);
		st_d.mdm_delta[2] = st_d.mdm_delta[2] | (~mdm_now[2] & st_q.mdm_prev[2]);
		st_d.mdm_delta[3] = st_d.mdm_delta[3] | (mdm_now[3] ^ st_q.mdm_prev[3]);

		// transmitter framing on the sixteen-times tick
		if (tick) begin
			case (st_q.tx_st)
				DASC_TX_IDLE: begin
					st_d.tx_line = 1'b1;
					if (!st_q.thr_empty) begin
						st_d.tx_shift  = st_q.tx_holding;
						st_d.thr_empty = 1'b1;
						st_d.thre_irq  = 1'b1;
						st_d.tx_st     = DASC_TX_START;
						st_d.tx_ovs    = 5'h00;
						st_d.tx_line   = 1'b0;
					end
				end
				DASC_TX_START, DASC_TX_DATA, DASC_TX_PAR: begin
					st_d.tx_ovs = st_q.tx_ovs + 5'h01;
					if (st_q.tx_ovs == `DASC_OVS - 5'h01) begin
						st_d.tx_ovs = 5'h00;
						if (st_q.tx_st == DASC_TX_START) begin
							st_d.tx_st   = DASC_TX_DATA;
							st_d.tx_bit  = 3'h0;
							st_d.tx_line = st_q.tx_shift[0];
						end else if (st_q.tx_st == DASC_TX_DATA && st_q.tx_bit != nbits) begin
							st_d.tx_bit  = st_q.tx_bit + 3'h1;
							st_d.tx_line = st_q.tx_shift[st_q.tx_bit + 3'h1];
						end else if (st_q.tx_st == DASC_TX_DATA
							&& st_q.line_format[`DASC_LF_PAR]) begin
							st_d.tx_st   = DASC_TX_PAR;
							st_d.tx_line = par_bit(st_q.tx_shift, st_q.line_format);
						end else begin
							st_d.tx_st   = DASC_TX_STOP;
							st_d.tx_line = 1'b1;
							st_d.tx_half = 1'b0;
						end
					end
				end
				DASC_TX_STOP: begin
					// one, one-and-half or two stop bits
					st_d.tx_ovs = st_q.tx_ovs + 5'h01;
					if (!st_q.line_format[`DASC_LF_STOP] && st_q.tx_ovs == 5'h0F ||
						st_q.line_format[`DASC_LF_STOP] && st_q.line_format[1:0] == 2'b00 &&
						st_q.tx_half && st_q.tx_ovs == 5'h07 ||
						st_q.tx_half && st_q.tx_ovs == 5'h0F) begin
						st_d.tx_st = DASC_TX_IDLE;
					end else if (st_q.tx_ovs == 5'h0F) begin
						st_d.tx_ovs  = 5'h00;
						st_d.tx_half = 1'b1;
					end
				end
				default: st_d.tx_st = DASC_TX_IDLE;
			endcase
		end

		// receiver: start qualified at centre; high is one
		if (tick) begin
			st_d.rx_ovs = st_q.rx_ovs + 4'h1;
			case (st_q.rx_st)
				DASC_RX_IDLE: begin
					st_d.rx_prev = rx_in;
					if (st_q.rx_prev && !rx_in) begin
						st_d.rx_st  = DASC_RX_START;
						st_d.rx_ovs = 4'h0;
					end
				end
				DASC_RX_START: begin
					if (st_q.rx_ovs == `DASC_START_MID) begin
						st_d.rx_ovs = 4'h0;
						st_d.rx_st  = rx_in ? DASC_RX_IDLE : DASC_RX_DATA;
						st_d.rx_bit = 3'h0;
						st_d.rx_zero = 1'b1;
						st_d.rx_shift = 8'h00;
						st_d.rx_prev = 1'b1;
					end
				end
				DASC_RX_DATA: begin
					if (st_q.rx_ovs == 4'hF) begin
						st_d.rx_shift[st_q.rx_bit] = rx_in;
						st_d.rx_zero = st_q.rx_zero & ~rx_in;
						st_d.rx_bit  = st_q.rx_bit + 3'h1;
						if (st_q.rx_bit == nbits) begin
							st_d.rx_st = st_q.line_format[`DASC_LF_PAR] ? DASC_RX_PAR
								: DASC_RX_STOP;
						end
					end
				end
				DASC_RX_PAR: begin
					if (st_q.rx_ovs == 4'hF) begin
						st_d.rx_par  = rx_in;
						st_d.rx_zero = st_q.rx_zero & ~rx_in;
						st_d.rx_st   = DASC_RX_STOP;
					end
				end
				DASC_RX_STOP: begin
					if (st_q.rx_ovs == 4'hF) begin
						// status set on stop; set wins over the read clear
						st_d.rx_holding = st_q.rx_shift;
						st_d.overrun    = st_d.overrun | st_q.data_ready;
						st_d.data_ready = 1'b1;
						st_d.frm_err    = st_d.frm_err | ~rx_in;
						st_d.brk        = st_d.brk | (st_q.rx_zero & ~rx_in);
						st_d.par_err    = st_d.par_err | (st_q.line_format[`DASC_LF_PAR] &
							(st_q.rx_par != par_bit(st_q.rx_shift, st_q.line_format)));
						st_d.rx_st      = DASC_RX_IDLE;
						st_d.rx_prev    = rx_in;
					end
				end
				default: st_d.rx_st = DASC_RX_IDLE;
			endcase
		end
	end

	function automatic logic [2:0] iid_code();
		logic le;
		le = st_q.overrun | st_q.par_err | st_q.frm_err | st_q.brk;
		if (st_q.irq_enable[2] && le) iid_code = `DASC_IID_LINE;
		else if (st_q.irq_enable[0] && st_q.data_ready) iid_code = `DASC_IID_RXD;
		else if (st_q.irq_enable[1] && st_q.thre_irq) iid_code = `DASC_IID_TXE;
		else if (st_q.irq_enable[3] && |st_q.mdm_delta) iid_code = `DASC_IID_MODEM;
		else iid_code = `DASC_IID_NONE;
	endfunction : iid_code

	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			st_q           <= '0;
			st_q.cs_s1     <= 3'h7;
			st_q.cs_s2     <= 3'h7;
			st_q.rd_s1     <= 3'h7;
			st_q.rd_s2     <= 3'h7;
			st_q.wr_s1     <= 3'h7;
			st_q.wr_s2     <= 3'h7;
			st_q.rd_prev   <= 1'b1;
			st_q.wr_prev   <= 1'b1;
			st_q.rx_s      <= 2'b11;
			st_q.mdm_s     <= 8'hFF;
			st_q.divisor   <= `DASC_DIV_RESET;
			st_q.thr_empty <= 1'b1;
			st_q.tx_line   <= 1'b1;
			st_q.rx_prev   <= 1'b1;
		end else begin
			st_q <= st_d;
		end
	end

	// mark on reset or loopback; interrupt pins
	assign o_tx               = st_q.tx_line | loop | i_rst;
	assign o_irq              = (iid != `DASC_IID_NONE);
	assign o_irq_oe           = st_q.modem_control[`DASC_MC_IRQEN];
	assign o_irq_enable_out_n = ~st_q.modem_control[`DASC_MC_IRQEN];
	// active-low modem outputs, forced high in loopback
	assign o_rts_n            = ~st_q.modem_control[1] | loop;
	assign o_dtr_n            = ~st_q.modem_control[0] | loop;
	assign o_rdata            = st_q.rdata;
	assign o_rdata_oe         = st_q.rd_act & ~st_q.rd_s2[0] & ~st_q.cs_s2[0];

	chk_ien_upper_zero: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		st_q.irq_enable[7:4] == 4'h0) else $error("enable upper bits set");
	// loopback or idle transmitter keeps mark
	chk_tx_loop_mark: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		(loop || st_q.tx_st == DASC_TX_IDLE) |-> o_tx) else $error("tx not mark when idle");
	chk_irq_pending: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		st_q.irq_enable[0] && st_q.data_ready |-> o_irq) else $error("irq missing");
	chk_rts_follow: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		!loop && $rose(st_q.modem_control[1]) |-> !o_rts_n) else $error("rts not low");
	chk_dtr_follow: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		!loop && !st_q.modem_control[0] |-> o_dtr_n) else $error("dtr not high");
	// enable output is inverse of output enable
	chk_irq_en_out: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		o_irq_enable_out_n == !o_irq_oe) else $error("enable out wrong");
	chk_no_sel_drive: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		i_bus.cs_n [*3] |-> !o_rdata_oe) else $error("driving while deselected");
	sequence s_tx_load;
		tick && st_q.tx_st == DASC_TX_IDLE && !st_q.thr_empty;
	endsequence
	chk_tx_start_low: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		s_tx_load ##1 !loop |-> !o_tx) else $error("no start bit");
	// a high line at centre aborts start
	chk_rx_false_start: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		tick && st_q.rx_st == DASC_RX_START && st_q.rx_ovs == `DASC_START_MID && rx_in
		|=> st_q.rx_st == DASC_RX_IDLE) else $error("false start accepted");
	// pending bit zero low when interrupt
	chk_iid_bit0: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		rd_fall && adr == `DASC_ADR_IID |=> o_rdata[0] != $past(o_irq))
		else $error("pending bit wrong");
endmodule : dasc_channel

// ==== sim/dasc_line_model.sv ====
// Purpose: Serial line and modem partner for one channel
// Assumes: Bench sets bit_ns to sixteen baud ticks of the channel
// Notes:   Captures twelve bit slots per frame, first slot is the start bit
`timescale 1ns/1ns
module dasc_line_model
	import dasc_pkg::*;
(
	input  wire logic      i_tx,
	output logic           o_rx,
	output dasc_modem_in_t o_modem
);
	int          bit_ns = 1600;
	int          frames = 0;
	logic [11:0] cap    = '1;

	// Line idles at mark, modem inputs inactive
	initial begin
		o_rx    = 1'b1;
		o_modem = '1;
	end

	always @(negedge i_tx) begin
		#(bit_ns / 2);
		for (int i = 0; i < 12; i++) begin
			cap[i] = i_tx;
			#(bit_ns);
		end
		frames++;
	end

	task automatic send(input logic [11:0] bits, input int n);
		for (int i = 0; i < n; i++) begin
			o_rx = bits[i];
			#(bit_ns);
		end
		o_rx = 1'b1;
	endtask : send

	// Short space pulse, too brief for a start bit
	task automatic glitch(input int ns);
		o_rx = 1'b0;
		#(ns);
		o_rx = 1'b1;
	endtask : glitch
endmodule : dasc_line_model

// ==== sim/dual_async_serial_channel_test.sv ====
// Purpose: Register-level tests of one serial channel
// Assumes: Divisor 2 gives 32 clocks per bit at reset
// Notes:   Write strobe held four clocks, read strobe five, so the two-flop inputs settle
`timescale 1ns/1ns
`include "dasc_defs.svh"
module dual_async_serial_channel_test
	import dasc_pkg::*;
;
	logic           sys_clk;
	logic           rst;
	dasc_bus_t      bus;
	logic [7:0]     rdata;
	logic           rdata_oe;
	logic           tx;
	logic           rx;
	logic           rts_n;
	logic           dtr_n;
	logic           irq;
	logic           irq_oe;
	logic           irq_en_n;
	dasc_modem_in_t modem;
	int             err_count = 0;
	int             checks    = 0;
	int             fc;
	logic [7:0]     rv;
	logic [7:0]     d;
	logic [11:0]    f;

	dasc_channel dut (
		.i_sys_clk          (sys_clk),
		.i_rst              (rst),
		.i_bus              (bus),
		.o_rdata            (rdata),
		.o_rdata_oe         (rdata_oe),
		.i_rx               (rx),
		.o_tx               (tx),
		.i_modem            (modem),
		.o_rts_n            (rts_n),
		.o_dtr_n            (dtr_n),
		.o_irq              (irq),
		.o_irq_oe           (irq_oe),
		.o_irq_enable_out_n (irq_en_n)
	);
	dasc_line_model line (
		.i_tx    (tx),
		.o_rx    (rx),
		.o_modem (modem)
	);

	// Free-running 20 MHz clock
	initial begin
		sys_clk = 1'b0;
		forever #25 sys_clk = ~sys_clk;
	end

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			err_count++;
			$display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic conclude();
		$display("checks %0d, mismatches %0d", checks, err_count);
		if (err_count == 0 && checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : conclude

	// Select set up one clock ahead of the strobe
	task automatic wr(input logic [2:0] a, input logic [7:0] v, input logic sel_n = 1'b0);
		@(posedge sys_clk);
		bus.cs_n  <= sel_n;
		bus.adr   <= a;
		bus.wdata <= v;
		@(posedge sys_clk);
		bus.wr_n <= 1'b0;
		repeat (4) @(posedge sys_clk);
		bus.wr_n <= 1'b1;
		@(posedge sys_clk);
		bus.cs_n <= 1'b1;
		repeat (3) @(posedge sys_clk);
	endtask : wr

	task automatic rd(input logic [2:0] a, output logic [7:0] v);
		@(posedge sys_clk);
		bus.cs_n <= 1'b0;
		bus.adr  <= a;
		bus.rd_n <= 1'b0;
		repeat (4) @(posedge sys_clk);
		#1;
		v = rdata;
		chk(rdata_oe, 1'b1);
		@(posedge sys_clk);
		bus.rd_n <= 1'b1;
		bus.cs_n <= 1'b1;
		repeat (3) @(posedge sys_clk);
		#1;
		chk(rdata_oe, 1'b0);
	endtask : rd

	// Bounded wait for the partner to finish capturing
	task automatic wait_frames(input int n);
		for (int i = 0; i < 20000 && line.frames < n; i++) begin
			@(posedge sys_clk);
		end
		if (line.frames < n) begin
			err_count++;
			$display("unexpected at %0t: no frame seen", $time);
			conclude();
		end
	endtask : wait_frames

	// Expected line levels: start, data LSB first, parity, then mark
	function automatic logic [11:0] frame(input logic [7:0] v, input int n,
		input logic pen, input logic even);
		logic [11:0] r;
		logic        p;
		r    = '1;
		r[0] = 1'b0;
		p    = ~even;
		for (int i = 0; i < n; i++) begin
			r[i + 1] = v[i];
			p        = p ^ v[i];
		end
		if (pen) begin
			r[n + 1] = p;
		end
		return r;
	endfunction : frame

	initial begin
		bus = '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, adr: 3'h0, wdata: 8'h00};
		rst = 1'b1;
		repeat (5) @(posedge sys_clk);
		#1;
		chk({tx, rts_n, dtr_n, irq_oe, irq_en_n}, 5'b11101);
		@(posedge sys_clk);
		rst <= 1'b0;
		rd(`DASC_ADR_LSTAT, rv);
		chk(rv, 8'h60);
		rd(`DASC_ADR_IID, rv);
		chk(rv, 8'h01);
		$display("test reset finished");

		// Registers, selection and refused writes
		wr(`DASC_ADR_SCR, 8'hA5);
		wr(`DASC_ADR_SCR, 8'h5A, 1'b1);
		rd(`DASC_ADR_SCR, rv);
		chk(rv, 8'hA5);
		wr(`DASC_ADR_IID, 8'hFF);
		rd(`DASC_ADR_IID, rv);
		chk(rv, 8'h01);
		wr(`DASC_ADR_IEN, 8'hFF);
		rd(`DASC_ADR_IEN, rv);
		chk(rv, 8'h0F);
		wr(`DASC_ADR_IEN, 8'h00);
		wr(`DASC_ADR_MCTL, 8'h0B);
		chk({rts_n, dtr_n, irq_oe, irq_en_n}, 4'b0010);
		wr(`DASC_ADR_MCTL, 8'h00);
		chk({rts_n, dtr_n, irq_oe, irq_en_n}, 4'b1101);
		$display("test registers finished");

		// Every word length, both parities, both stop settings
		for (int w = 0; w < 4; w++) begin
			wr(`DASC_ADR_LFMT, {3'b000, w[0], 1'b1, w[1], w[1:0]});
			d  = 8'hC5 + 8'(w);
			fc = line.frames;
			wr(`DASC_ADR_DATA, d);
			wait_frames(fc + 1);
			chk(line.cap, frame(d, w + 5, 1'b1, w[0]));
		end
		$display("test transmit finished");

		// Good frame, bad parity, then a noise spike
		wr(`DASC_ADR_LFMT, 8'h1B);
		line.send(frame(8'h96, 8, 1'b1, 1'b1), 11);
		repeat (40) @(posedge sys_clk);
		rd(`DASC_ADR_LSTAT, rv);
		chk(rv, 8'h61);
		rd(`DASC_ADR_DATA, rv);
		chk(rv, 8'h96);
		f    = frame(8'h96, 8, 1'b1, 1'b1);
		f[9] = ~f[9];
		line.send(f, 11);
		repeat (40) @(posedge sys_clk);
		rd(`DASC_ADR_LSTAT, rv);
		chk(rv, 8'h65);
		rd(`DASC_ADR_DATA, rv);
		line.glitch(300);
		repeat (600) @(posedge sys_clk);
		rd(`DASC_ADR_LSTAT, rv);
		chk(rv, 8'h60);
		$display("test receive finished");

		// Transmit-empty then receive-data interrupt
		wr(`DASC_ADR_MCTL, 8'h08);
		wr(`DASC_ADR_IEN, 8'h02);
		chk(irq, 1'b1);
		rd(`DASC_ADR_IID, rv);
		chk(rv, 8'h02);
		chk(irq, 1'b0);
		wr(`DASC_ADR_IEN, 8'h01);
		line.send(frame(8'h3C, 8, 1'b1, 1'b1), 11);
		repeat (40) @(posedge sys_clk);
		chk(irq, 1'b1);
		rd(`DASC_ADR_IID, rv);
		chk(rv, 8'h04);
		rd(`DASC_ADR_DATA, rv);
		chk(irq, 1'b0);
		wr(`DASC_ADR_IEN, 8'h00);
		$display("test interrupt finished");

		// Modem change flag set, then cleared by the read
		@(posedge sys_clk);
		line.o_modem.cts_n <= 1'b0;
		line.o_modem.cd_n  <= 1'b0;
		repeat (10) @(posedge sys_clk);
		rd(`DASC_ADR_MSTAT, rv);
		chk(rv, 8'h99);
		rd(`DASC_ADR_MSTAT, rv);
		chk(rv, 8'h90);
		$display("test modem finished");

		// Loopback: pin stays mark, outside frame ignored
		wr(`DASC_ADR_MCTL, 8'h1B);
		chk({tx, rts_n, dtr_n}, 3'b111);
		rd(`DASC_ADR_MSTAT, rv);
		chk(rv & 8'hF0, 8'hB0);
		fc = line.frames;
		fork
			wr(`DASC_ADR_DATA, 8'h5A);
			line.send(frame(8'h81, 8, 1'b1, 1'b1), 11);
		join
		repeat (200) @(posedge sys_clk);
		rd(`DASC_ADR_DATA, rv);
		chk(rv, 8'h5A);
		chk(16'(line.frames), 16'(fc));
		$display("test loopback finished");

		// Divisor of four doubles the bit time
		wr(`DASC_ADR_MCTL, 8'h00);
		wr(`DASC_ADR_LFMT, 8'h83);
		wr(`DASC_ADR_DATA, 8'h04);
		wr(`DASC_ADR_IEN, 8'h00);
		rd(`DASC_ADR_DATA, rv);
		chk(rv, 8'h04);
		wr(`DASC_ADR_LFMT, 8'h03);
		line.bit_ns = 3200;
		fc          = line.frames;
		wr(`DASC_ADR_DATA, 8'hE1);
		wait_frames(fc + 1);
		chk(line.cap, frame(8'hE1, 8, 1'b0, 1'b0));
		$display("test divisor finished");
		conclude();
	end
endmodule : dual_async_serial_channel_test
